// ===== hw/instrument_bus_sequencer.sv
/*
  controller-side sequencer: response and data-out bytes, abort,
  parallel poll and lockout line sequences.
  assumes host writes and requests are synchronous to core_clk.
*/
// Functional notes
// R1: during parallel poll, data lines follow the poll response byte, bit7 to DIO8.
// R2: host zeroes the poll response byte at start and when unconfigured.
// R3: data-out byte goes on data lines, bit 7 on DIO8, bit 0 on DIO1; a write in a sequence's last cycle misses dioOut; a clear never enables drive.
// R4: uniline messages on control lines, multiline commands as data bytes.
// R5: ATN level holds across steps and sequences until explicitly changed.
// R6: ATN never toggled when the needed level is unchanged.
// R7: abort as system controller: IFC 100 us, then REN, ATN false, become active.
// R8: parallel poll: ATN and EOI 25 us, capture byte, restore ATN; refuse if inactive.
`timescale 1ns/1ps
module instrument_bus_sequencer
  import bus_seq_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       byteRegisterWrite,
  input  wire logic [4:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       abortBusRequest,
  input  wire logic       parallelPollRequest,
  input  wire logic       frontPanelLockoutRequest,
  input  wire logic       systemController,
  input  wire logic [7:0] dioIn,
  output logic [7:0]      dioOut,
  output logic            dioOe_n,
  output logic            atnOut,
  output logic            eoiOut,
  output logic            ifcOut,
  output logic            renOut,
  output logic            activeController,
  output logic [7:0]      pollResult,
  output logic            seqBusy,
  output logic            seqDone,
  output logic            seqError
);
  import bus_seq_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum {S_IDLE, S_IFC, S_POLL, S_LLO} state_t;

  localparam logic [7:0] LLO_BYTE = 8'h11;

  state_t     state_r, state_nxt;
  logic [7:0] ppResp_r, ppResp_nxt;
  logic [7:0] dataOut_r, dataOut_nxt;
  logic [7:0] dio_r, dio_nxt;
  logic       dioOe_r, dioOe_nxt;
  logic       atn_r, atn_nxt;
  logic       atnSaved_r, atnSaved_nxt;
  logic       eoi_r, eoi_nxt;
  logic       ifc_r, ifc_nxt;
  logic       ren_r, ren_nxt;
  logic       ac_r, ac_nxt;
  logic [7:0] poll_r, poll_nxt;
  logic       busy_r, busy_nxt;
  logic       done_r, done_nxt;
  logic       err_r, err_nxt;
  logic       tLoad;
  logic [CNT_W-1:0] tValue;
  logic       tDone;

  hold_timer hold_timer_inst (
    .core_clk  (core_clk),
    .rst       (rst),
    .load      (tLoad),
    .loadValue (tValue),
    .done      (tDone)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    state_nxt    = state_r;
    ppResp_nxt   = ppResp_r;
    dataOut_nxt  = dataOut_r;
    dio_nxt      = dio_r;
    dioOe_nxt    = dioOe_r;
    atn_nxt      = atn_r;   // R5
    atnSaved_nxt = atnSaved_r;
    eoi_nxt      = eoi_r;
    ifc_nxt      = ifc_r;
    ren_nxt      = ren_r;
    ac_nxt       = ac_r;
    poll_nxt     = poll_r;
    busy_nxt     = busy_r;
    done_nxt     = 1'b0;
    err_nxt      = 1'b0;
    tLoad        = 1'b0;
    tValue       = '0;

    // register writes land in any state; the poll byte is only sampled later
    if (byteRegisterWrite && regAddr == POLL_RESP_OFS)
      ppResp_nxt = regWrData;
    if (byteRegisterWrite && regAddr == DATA_OUT_OFS)
    begin
      dataOut_nxt = regWrData;
      if (state_r == S_IDLE)
      begin
        dio_nxt   = regWrData; // R3
        dioOe_nxt = 1'b0;
      end
    end

    case (state_r)
      S_IDLE:
      begin
        if (abortBusRequest)
        begin
          if (systemController)
          begin
            ifc_nxt   = 1'b1; // R7
            tLoad     = 1'b1;
            tValue    = CNT_W'(IFC_CYCLES);
            busy_nxt  = 1'b1;
            state_nxt = S_IFC;
          end
          else
            done_nxt = 1'b1;
        end
        else if (parallelPollRequest)
        begin
          if (!ac_r)
            err_nxt = 1'b1; // R8
          else
          begin
            atnSaved_nxt = atn_r;
            atn_nxt      = 1'b1;
            eoi_nxt      = 1'b1; // R8
            dio_nxt      = ppResp_r; // R1
            dioOe_nxt    = 1'b0;
            tLoad        = 1'b1;
            tValue       = CNT_W'(POLL_CYCLES);
            busy_nxt     = 1'b1;
            state_nxt    = S_POLL;
          end
        end
        else if (frontPanelLockoutRequest)
        begin
          if (!ac_r)
            err_nxt = 1'b1;
          else
          begin
            atn_nxt   = 1'b1; // R4
            dio_nxt   = LLO_BYTE; // R4
            dioOe_nxt = 1'b0;
            busy_nxt  = 1'b1;
            state_nxt = S_LLO;
          end
        end
      end
      S_IFC:
      begin
        if (tDone)
        begin
          ifc_nxt   = 1'b0;
          // a data-out write taken before the last clear cycle reaches dioOut only now, with dioOe_n left as it was
          dio_nxt   = dataOut_r; // R3
          ren_nxt   = 1'b1; // R7
          atn_nxt   = 1'b0; // R7
          ac_nxt    = 1'b1; // R7
          busy_nxt  = 1'b0;
          done_nxt  = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      S_POLL:
      begin
        if (tDone)
        begin
          // our own drive is wired-or onto the lines, so the capture includes it
          poll_nxt  = dioIn; // R8
          eoi_nxt   = 1'b0;
          atn_nxt   = atnSaved_r; // R6
          dio_nxt   = dataOut_r;
          busy_nxt  = 1'b0;
          done_nxt  = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      S_LLO:
      begin
        // atn stays true afterwards to avoid a needless transition
        dio_nxt   = dataOut_r; // R3
        busy_nxt  = 1'b0;
        done_nxt  = 1'b1;
        state_nxt = S_IDLE;
      end
      default:
        state_nxt = S_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r    <= S_IDLE;
      ppResp_r   <= BYTE_RST;
      dataOut_r  <= BYTE_RST;
      dio_r      <= BYTE_RST;
      dioOe_r    <= 1'b1;
      atn_r      <= 1'b0;
      atnSaved_r <= 1'b0;
      eoi_r      <= 1'b0;
      ifc_r      <= 1'b0;
      ren_r      <= 1'b0;
      ac_r       <= 1'b0;
      poll_r     <= BYTE_RST;
      busy_r     <= 1'b0;
      done_r     <= 1'b0;
      err_r      <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      ppResp_r   <= ppResp_nxt;
      dataOut_r  <= dataOut_nxt;
      dio_r      <= dio_nxt;
      dioOe_r    <= dioOe_nxt;
      atn_r      <= atn_nxt;
      atnSaved_r <= atnSaved_nxt;
      eoi_r      <= eoi_nxt;
      ifc_r      <= ifc_nxt;
      ren_r      <= ren_nxt;
      ac_r       <= ac_nxt;
      poll_r     <= poll_nxt;
      busy_r     <= busy_nxt;
      done_r     <= done_nxt;
      err_r      <= err_nxt;
    end
  end

  assign dioOut           = dio_r;
  assign dioOe_n          = dioOe_r;
  assign atnOut           = atn_r;
  assign eoiOut           = eoi_r;
  assign ifcOut           = ifc_r;
  assign renOut           = ren_r;
  assign activeController = ac_r;
  assign pollResult       = poll_r;
  assign seqBusy          = busy_r;
  assign seqDone          = done_r;
  assign seqError         = err_r;
endmodule

// ===== shared/bus_seq_pkg.sv
/*
  constants and types for the instrument bus sequencer.
  assumes a single 50 MHz core clock.
*/
package bus_seq_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [4:0] POLL_RESP_OFS = 5'h1D;
  localparam logic [4:0] DATA_OUT_OFS  = 5'h1F;
  localparam logic [7:0] BYTE_RST      = 8'h00;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ        = 50;
  localparam int IFC_MIN_US     = 100;
  localparam int POLL_MIN_US    = 25;
  localparam int IFC_CYCLES     = IFC_MIN_US * CLK_MHZ;
  localparam int POLL_CYCLES    = POLL_MIN_US * CLK_MHZ;
  localparam int CNT_W          = 13;

  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_ABORT,
    CMD_POLL,
    CMD_LOCKOUT
  } seq_cmd_t;
endpackage

// ===== hw/hold_timer.sv
/*
  down counter used to stretch bus line assertions.
  assumes load and the load value come from the sequencer in the same domain.
*/
`timescale 1ns/1ps
module hold_timer
  import bus_seq_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] loadValue,
  output logic                  done
);
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;

  always_comb
  begin
    count_nxt = count_r;
    if (load)
      count_nxt = loadValue;
    else if (count_r != '0)
      count_nxt = count_r - 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      count_r <= '0;
    else
      count_r <= count_nxt;
  end

  assign done = (count_r == '0) && !load;
endmodule

// ===== verif/instrument_bus_sequencer_sva.sv
/* port checker for the bus sequencer.
   assumes binding to the top module. */
`timescale 1ns/1ps
module instrument_bus_sequencer_sva
  import bus_seq_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       byteRegisterWrite,
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       abortBusRequest,
  input wire logic       parallelPollRequest,
  input wire logic       frontPanelLockoutRequest,
  input wire logic       systemController,
  input wire logic [7:0] dioOut,
  input wire logic       dioOe_n,
  input wire logic       atnOut,
  input wire logic       eoiOut,
  input wire logic       ifcOut,
  input wire logic       renOut,
  input wire logic       activeController,
  input wire logic       seqBusy,
  input wire logic       seqError
);
  // ----------------------------------------
  // line stretch counter
  // ----------------------------------------
  // ifc and eoi never overlap, so one counter serves both
  logic [12:0] hiCnt_r;
  logic [12:0] hiCnt_nxt;
  logic        idle;
  assign idle = !seqBusy && !abortBusRequest;
  always_comb hiCnt_nxt = (ifcOut || eoiOut) ? hiCnt_r + 13'h1 : 13'h0;
  always_ff @(posedge core_clk or posedge rst)
    if (rst) hiCnt_r <= 13'h0;
    else hiCnt_r <= hiCnt_nxt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  poll_start_a: assert property (idle && parallelPollRequest && activeController
    |=> atnOut && eoiOut && seqBusy) else $error("poll start");
  poll_refuse_a: assert property (idle && parallelPollRequest && !activeController
    |=> seqError) else $error("poll refuse");
  poll_len_a: assert property ($fell(eoiOut) |-> hiCnt_r >= POLL_CYCLES)
    else $error("poll short");
  poll_drive_a: assert property (eoiOut |-> !dioOe_n && atnOut) else $error("poll lines");
  abort_ifc_a: assert property (idle ##0 $rose(abortBusRequest) && systemController
    |=> ifcOut && seqBusy) else $error("ifc start");
  ifc_len_a: assert property ($fell(ifcOut) |-> hiCnt_r >= IFC_CYCLES) else $error("ifc");
  abort_end_a: assert property ($fell(ifcOut) |-> renOut && !atnOut && activeController)
    else $error("abort end");
  atn_keep_a: assert property ($changed(atnOut) |-> seqBusy || $past(seqBusy))
    else $error("atn moved");
  data_out_a: assert property (idle && !parallelPollRequest && !frontPanelLockoutRequest
    && byteRegisterWrite && regAddr == DATA_OUT_OFS
    |=> dioOut == $past(regWrData) && !dioOe_n) else $error("data out");
endmodule

// ===== verif/bus_instrument_model.sv
/* instruments on the bus answering a poll.
   assumes released lines read false. */
`timescale 1ns/1ps
module bus_instrument_model (
  input wire logic [7:0] dioOut,
  input wire logic       dioOe_n,
  input wire logic       atnOut,
  input wire logic       eoiOut,
  input wire logic [7:0] instResp,
  output logic [7:0]     dioIn
);
  // ----------------------------------------
  // wired-or data lines
  // ----------------------------------------
  // pull-ups make a released line false, never a stale byte
  assign dioIn = (dioOe_n ? 8'h00 : dioOut) | ((atnOut && eoiOut) ? instResp : 8'h00);
endmodule

// ===== verif/instrument_bus_sequencer_tb.sv
/* self-checking bench for the bus sequencer.
   assumes the instrument model and checker. */
`timescale 1ns/1ps
module instrument_bus_sequencer_tb;
  import bus_seq_pkg::*;
  // ----------------------------------------
  // signals and helpers
  // ----------------------------------------
  logic core_clk = 0, rst = 1, byteRegisterWrite = 0, systemController = 1;
  logic abortBusRequest = 0, parallelPollRequest = 0, frontPanelLockoutRequest = 0;
  logic dioOe_n, atnOut, eoiOut, ifcOut, renOut, activeController, seqBusy, seqDone, seqError;
  logic [4:0] regAddr = 5'h00;
  logic [7:0] regWrData = 8'h00, instResp = 8'h00, dioIn, dioOut, pollResult, seed, resp, dat;
  int         miscompares = 0, comparisons = 0, n, hi;
  always #10 core_clk = ~core_clk;
  instrument_bus_sequencer instrument_bus_sequencer_inst (.*);
  bus_instrument_model bus_instrument_model_inst (.*);
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] pollExpect(input logic [7:0] r, input logic [7:0] i);
    return r | i;
  endfunction
  task chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task results;
    if (miscompares == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {byteRegisterWrite, regAddr, regWrData} = {1'b1, a, d};
    @(negedge core_clk);
    byteRegisterWrite = 0;
  endtask
  // pulses abort, poll, lockout; returns at the first answer cycle
  task go(input logic [2:0] k);
    @(negedge core_clk);
    {abortBusRequest, parallelPollRequest, frontPanelLockoutRequest} = k;
    @(negedge core_clk);
    {abortBusRequest, parallelPollRequest, frontPanelLockoutRequest} = 3'h0;
  endtask
  task waitEnd;
    n = 0;
    hi = 0;
    while (seqDone !== 1'b1 && seqError !== 1'b1 && n < 9000)
    begin
      hi += ifcOut | eoiOut;
      n++;
      @(negedge core_clk);
    end
    chk(n < 9000, "hang");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    seed = 8'h33;
    repeat (6) @(negedge core_clk);
    rst = 0;
    wr(POLL_RESP_OFS, BYTE_RST);
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      dat = seed;
      wr(DATA_OUT_OFS, dat);
      chk(dioOut === dat && dioOe_n === 1'b0, "data out");
    end
    wr(5'h1E, ~dat);
    chk(dioOut === dat, "unmapped write");
    go(3'h2);
    chk(seqError === 1'b1 && atnOut === 1'b0, "poll refused");
    go(3'h4);
    chk(ifcOut === 1'b1, "ifc start");
    waitEnd;
    chk(hi >= IFC_CYCLES && renOut && !atnOut && activeController, "abort");
    for (int p = 0; p < 2; p++)
    begin
      seed = lfsr(seed);
      resp = seed;
      seed = lfsr(seed);
      instResp = seed;
      wr(POLL_RESP_OFS, resp);
      go(3'h2);
      chk(dioOut === resp && atnOut && eoiOut, "poll drive");
      waitEnd;
      chk(hi >= POLL_CYCLES && pollResult === pollExpect(resp, seed), "poll byte");
      chk(atnOut === p[0] && eoiOut === 1'b0 && dioOut === dat, "poll restore");
      go(3'h1);
      chk(dioOut === 8'h11 && atnOut === 1'b1, "lockout");
      waitEnd;
    end
    wr(POLL_RESP_OFS, BYTE_RST);
    systemController = 0;
    go(3'h4);
    chk(seqDone === 1'b1 && ifcOut === 1'b0 && atnOut === 1'b1, "abort ignored");
    // mid-run reset drops the controller role and releases the lines
    @(negedge core_clk);
    rst = 1;
    @(negedge core_clk);
    rst = 0;
    chk(dioOe_n === 1'b1 && atnOut === 1'b0 && activeController === 1'b0, "reset");
    go(3'h2);
    chk(seqError === 1'b1 && eoiOut === 1'b0, "poll after reset");
    results;
  end
  initial
  begin
    #400000;
    miscompares++;
    results;
  end
endmodule
bind instrument_bus_sequencer instrument_bus_sequencer_sva instrument_bus_sequencer_sva_inst (.*);
